// >>> verilog/fscd_pkg.sv
// ****************************************************************
// Package for the setting command decoder
// ****************************************************************
package fscd_pkg;

   // ****************************************************************
   // Opcodes
   // ****************************************************************
   localparam logic [7:0] OPC_LATCH_SET       = 8'h06;
   localparam logic [7:0] OPC_LATCH_CLEAR     = 8'h04;
   localparam logic [7:0] OPC_STATUS_READ     = 8'h05;
   localparam logic [7:0] OPC_CONFIG_READ     = 8'h15;
   localparam logic [7:0] OPC_STATUS_CFG_WR   = 8'h01;
   localparam logic [7:0] OPC_PROTECT_SELECT  = 8'h68;
   localparam logic [7:0] OPC_QUAD_ENTER      = 8'h35;
   localparam logic [7:0] OPC_QUAD_EXIT       = 8'hf5;
   localparam logic [7:0] OPC_SUSPEND         = 8'hb0;
   localparam logic [7:0] OPC_RESUME          = 8'h30;
   localparam logic [7:0] OPC_POWER_DOWN      = 8'hb9;
   localparam logic [7:0] OPC_POWER_RELEASE   = 8'hab;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam int         AXI_AW              = 8;
   localparam logic [7:0] OFF_STATUS          = 8'h00;
   localparam logic [7:0] OFF_CONFIG          = 8'h04;
   localparam logic [7:0] OFF_CONTROL         = 8'h08;
   localparam logic [7:0] OFF_STATE           = 8'h0c;
   localparam logic [7:0] RST_STATUS          = 8'h00;
   localparam logic [7:0] RST_CONFIG          = 8'h00;
   localparam int         CTL_BUSY_BIT        = 0;
   localparam int         ST_LATCH_BIT        = 0;
   localparam int         ST_QUAD_BIT         = 1;
   localparam int         ST_PROT_BIT         = 2;
   localparam int         ST_SUSP_BIT         = 3;
   localparam int         ST_PD_BIT           = 4;
   localparam int         ST_OPC_LSB          = 8;
   localparam logic [1:0] RESP_OKAY           = 2'b00;
   localparam logic [1:0] RESP_DECERR         = 2'b11;

   // ****************************************************************
   // Link pins and session
   // ****************************************************************
   typedef struct packed {
      logic       cs_n;
      logic       sclk;
      logic [3:0] io;
   } fscd_link_t;

   localparam logic [5:0] LINK_IDLE           = 6'h20;
   localparam logic [3:0] OE_N_OFF            = 4'hf;
   localparam logic [3:0] OE_N_SINGLE         = 4'hd;
   localparam logic [3:0] OE_N_QUAD           = 4'h0;

   typedef enum logic [1:0] {
      st_cmd  = 2'b00,
      st_data = 2'b01,
      st_read = 2'b11,
      st_skip = 2'b10
   } fscd_state_t;

endpackage

// >>> verilog/fscd_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// Two flip-flop synchroniser
// ****************************************************************
module fscd_sync #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         arst_n,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= INIT;
         q      <= INIT;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule

// >>> verilog/fscd_top.sv
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// [RQ1] Opcode 06h sets the write enable latch in either mode, no extra bytes.
// [RQ2] Opcode 04h clears the write enable latch in either mode, no extra bytes.
// [RQ3] After 05h the status register is shifted out on the data lines.
// [RQ4] After 15h the configuration register is shifted out on the data lines.
// [RQ5] Opcode 01h takes one or two bytes: status, then optional configuration.
// [RQ6] Opcode 68h selects the individual block protect scheme.
// [RQ7] Opcode 35h enters four-line mode, accepted only in single-line mode.
// [RQ8] Opcode F5h leaves four-line mode, accepted only in four-line mode.
// [RQ9] B0h suspends a running program or erase, 30h resumes it.
// [RQ10] B9h enters deep power-down in either mode.
// [RQ11] ABh leaves deep power-down and restores normal command acceptance.
// [RQ12] Four-line mode uses four lines throughout; quad enable bit untouched.
// [RQ13] After exit, opcodes are taken one bit per clock on one line.
// [RQ14] Host keeps chip select high the write deselect time after mode changes.
// [RQ15] Opcodes arrive MSB first: one bit or one nibble per clock.
// [RQ16] Invalid opcodes are ignored until chip select is deasserted.
module fscd_top (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // Serial link
   input  wire logic        cs_n,
   input  wire logic        sclk,
   input  wire logic [3:0]  io_i,
   output logic      [3:0]  io_o,
   output logic      [3:0]  io_oe_n,
   // AXI4-Lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic      [1:0]  s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic      [31:0] s_axi_rdata,
   output logic      [1:0]  s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Device state
   output logic             write_enable_latch,
   output logic             four_line_command_mode,
   output logic             individual_protect,
   output logic             op_suspended,
   output logic             deep_power_down
);

   // ****************************************************************
   // Reset release and pin synchronisation
   // ****************************************************************
   logic                 rst_n;
   fscd_pkg::fscd_link_t link_raw;
   fscd_pkg::fscd_link_t link_s;

   fscd_sync #(.W(1), .INIT(1'b0)) u_rst_sync (
      .clk    (mclk),
      .arst_n (reset_n),
      .d      (1'b1),
      .q      (rst_n)
   );

   assign link_raw.cs_n = cs_n;
   assign link_raw.sclk = sclk;
   assign link_raw.io   = io_i;

   fscd_sync #(.W(6), .INIT(fscd_pkg::LINK_IDLE)) u_link_sync (
      .clk    (mclk),
      .arst_n (rst_n),
      .d      (link_raw),
      .q      (link_s)
   );

   // ****************************************************************
   // Edge detection
   // ****************************************************************
   logic cs_prev_q;
   logic sclk_prev_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cs_prev_q   <= 1'b1;
         sclk_prev_q <= 1'b0;
      end else begin
         cs_prev_q   <= link_s.cs_n;
         sclk_prev_q <= link_s.sclk;
      end
   end

   wire active    = ~link_s.cs_n;
   wire cs_rise   = link_s.cs_n & ~cs_prev_q;
   wire sclk_rise = active & link_s.sclk & ~sclk_prev_q;
   wire sclk_fall = active & ~link_s.sclk & sclk_prev_q;

   // ****************************************************************
   // Device state registers
   // ****************************************************************
   fscd_pkg::fscd_state_t state_q, state_d;
   logic [7:0] sh_q, sh_d, opc_q, opc_d, out_q, out_d;
   logic [7:0] new_sr_q, new_sr_d, new_cr_q, new_cr_d, sr_q, sr_d, cr_q, cr_d;
   logic [2:0] bit_cnt_q, bit_cnt_d, left_q, left_d;
   logic [3:0] io_o_q, io_o_d, oe_n_q, oe_n_d;
   logic [1:0] data_cnt_q, data_cnt_d;
   logic       exec_q, exec_d, wel_q, quad_q, prot_q, susp_q, pd_q, busy_q;
   logic       wel_d, quad_d, prot_d, susp_d, pd_d, busy_d;

   // ****************************************************************
   // Serial shifter
   // ****************************************************************
   // [RQ12] four lines in quad mode
   wire [3:0] step      = quad_q ? 4'd4 : 4'd1;
   wire [3:0] bit_sum   = {1'b0, bit_cnt_q} + step;
   wire       byte_done = sclk_rise & bit_sum[3];
   // [RQ15] MSB first shifting
   // [RQ13] single line after exit
   wire [7:0] sh_next   = quad_q ? {sh_q[3:0], link_s.io} : {sh_q[6:0], link_s.io[0]};

   wire op_set  = sh_next == fscd_pkg::OPC_LATCH_SET;
   wire op_clr  = sh_next == fscd_pkg::OPC_LATCH_CLEAR;
   wire op_rsr  = sh_next == fscd_pkg::OPC_STATUS_READ;
   wire op_rcr  = sh_next == fscd_pkg::OPC_CONFIG_READ;
   wire op_wr   = sh_next == fscd_pkg::OPC_STATUS_CFG_WR;
   wire op_prot = sh_next == fscd_pkg::OPC_PROTECT_SELECT;
   wire op_qen  = sh_next == fscd_pkg::OPC_QUAD_ENTER;
   wire op_qex  = sh_next == fscd_pkg::OPC_QUAD_EXIT;
   wire op_sus  = sh_next == fscd_pkg::OPC_SUSPEND;
   wire op_res  = sh_next == fscd_pkg::OPC_RESUME;
   wire op_pd   = sh_next == fscd_pkg::OPC_POWER_DOWN;
   wire op_rel  = sh_next == fscd_pkg::OPC_POWER_RELEASE;
   // [RQ7] enter only from single line
   wire ok_qen  = op_qen & ~quad_q;
   // [RQ8] exit only from four lines
   wire ok_qex  = op_qex & quad_q;
   // [RQ11] only release is heard in power-down
   wire nodata  = pd_q ? op_rel : (op_set | op_clr | op_prot | ok_qen | ok_qex
                                   | op_sus | op_res | op_pd | op_rel);
   wire rd_cmd  = ~pd_q & (op_rsr | op_rcr);
   wire wr_cmd  = ~pd_q & op_wr;

   wire in_cmd  = state_q == fscd_pkg::st_cmd;
   wire in_data = state_q == fscd_pkg::st_data;
   wire in_read = state_q == fscd_pkg::st_read;

   // ****************************************************************
   // Session sequencing
   // ****************************************************************
   always_comb begin
      state_d    = state_q;
      sh_d       = sh_q;
      bit_cnt_d  = bit_cnt_q;
      opc_d      = opc_q;
      exec_d     = exec_q;
      data_cnt_d = data_cnt_q;
      new_sr_d   = new_sr_q;
      new_cr_d   = new_cr_q;
      if (!active) begin
         state_d    = fscd_pkg::st_cmd;
         bit_cnt_d  = 3'd0;
         exec_d     = 1'b0;
         data_cnt_d = 2'd0;
      end else if (sclk_rise) begin
         sh_d      = sh_next;
         bit_cnt_d = bit_sum[2:0];
         case (state_q)
            fscd_pkg::st_cmd: begin
               if (byte_done) begin
                  opc_d = sh_next;
                  if (rd_cmd) begin
                     state_d = fscd_pkg::st_read;
                  end else if (wr_cmd) begin
                     state_d = fscd_pkg::st_data;
                  end else begin
                     // [RQ16] unknown opcode is dropped
                     state_d = fscd_pkg::st_skip;
                     exec_d  = nodata;
                  end
               end
            end
            fscd_pkg::st_data: begin
               if (byte_done) begin
                  // [RQ5] first status, then config
                  case (data_cnt_q)
                     2'd0:    new_sr_d = sh_next;
                     2'd1:    new_cr_d = sh_next;
                     default: state_d = fscd_pkg::st_skip;
                  endcase
                  data_cnt_d = data_cnt_q + 2'd1;
               end
            end
            fscd_pkg::st_skip: begin
               // Clocks after a no-data opcode cancel it
               exec_d = 1'b0;
            end
            default: ;
         endcase
      end
   end

   wire ap       = cs_rise & exec_q;
   wire ap_wr    = cs_rise & in_data & (bit_cnt_q == 3'd0)
                   & ((data_cnt_q == 2'd1) | (data_cnt_q == 2'd2));
   wire ap_cfg   = ap_wr & (data_cnt_q == 2'd2);
   wire ex_set   = ap & (opc_q == fscd_pkg::OPC_LATCH_SET);
   wire ex_clr   = ap & (opc_q == fscd_pkg::OPC_LATCH_CLEAR);
   wire ex_prot  = ap & (opc_q == fscd_pkg::OPC_PROTECT_SELECT);
   wire ex_qen   = ap & (opc_q == fscd_pkg::OPC_QUAD_ENTER);
   wire ex_qex   = ap & (opc_q == fscd_pkg::OPC_QUAD_EXIT);
   wire ex_sus   = ap & (opc_q == fscd_pkg::OPC_SUSPEND);
   wire ex_res   = ap & (opc_q == fscd_pkg::OPC_RESUME);
   wire ex_pd    = ap & (opc_q == fscd_pkg::OPC_POWER_DOWN);
   wire ex_rel   = ap & (opc_q == fscd_pkg::OPC_POWER_RELEASE);

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   logic        aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q, rdata_q;
   logic [3:0]  w_strb_q;
   logic [1:0]  bresp_q, rresp_q;

   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take  = s_axi_wvalid & s_axi_wready;
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire wr_go   = aw_hold_q & w_hold_q & ~bvalid_q;
   wire wr_map  = aw_addr_q[7:4] == 4'h0;
   wire lane0   = wr_go & w_strb_q[0];
   wire sw_sr   = lane0 & (aw_addr_q == fscd_pkg::OFF_STATUS);
   wire sw_cr   = lane0 & (aw_addr_q == fscd_pkg::OFF_CONFIG);
   wire sw_ctl  = lane0 & (aw_addr_q == fscd_pkg::OFF_CONTROL);

   wire [31:0] state_word = ({31'h0, wel_q}  << fscd_pkg::ST_LATCH_BIT)
                          | ({31'h0, quad_q} << fscd_pkg::ST_QUAD_BIT)
                          | ({31'h0, prot_q} << fscd_pkg::ST_PROT_BIT)
                          | ({31'h0, susp_q} << fscd_pkg::ST_SUSP_BIT)
                          | ({31'h0, pd_q}   << fscd_pkg::ST_PD_BIT)
                          | ({24'h0, opc_q}  << fscd_pkg::ST_OPC_LSB);
   wire        rd_map  = s_axi_araddr[7:4] == 4'h0;
   wire [31:0] rd_word = (s_axi_araddr == fscd_pkg::OFF_STATUS)  ? {24'h0, sr_q} :
                         (s_axi_araddr == fscd_pkg::OFF_CONFIG)  ? {24'h0, cr_q} :
                         (s_axi_araddr == fscd_pkg::OFF_CONTROL) ? {31'h0, busy_q} :
                         (s_axi_araddr == fscd_pkg::OFF_STATE)   ? state_word : 32'h0;

   assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
   assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0;
         w_strb_q  <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= fscd_pkg::RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_map ? fscd_pkg::RESP_OKAY : fscd_pkg::RESP_DECERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0;
         rresp_q  <= fscd_pkg::RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_word;
         rresp_q  <= rd_map ? fscd_pkg::RESP_OKAY : fscd_pkg::RESP_DECERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // [RQ1] latch set
   // [RQ2] latch clear
   assign wel_d  = ex_set ? 1'b1 : (ex_clr ? 1'b0 : wel_q);
   // [RQ7] enter four-line mode
   // [RQ8] leave four-line mode
   assign quad_d = ex_qen ? 1'b1 : (ex_qex ? 1'b0 : quad_q);
   // [RQ6] individual block protect
   assign prot_d = ex_prot | prot_q;
   // [RQ9] suspend needs a running operation
   assign susp_d = (ex_sus & busy_q) ? 1'b1 : (ex_res ? 1'b0 : susp_q);
   // [RQ10] enter power-down
   // [RQ11] release power-down
   assign pd_d   = ex_pd ? 1'b1 : (ex_rel ? 1'b0 : pd_q);
   assign busy_d = sw_ctl ? w_data_q[fscd_pkg::CTL_BUSY_BIT] : busy_q;
   // [RQ5] link write wins over a bus write
   // [RQ12] mode changes leave status alone
   assign sr_d   = ap_wr ? new_sr_q : (sw_sr ? w_data_q[7:0] : sr_q);
   assign cr_d   = ap_cfg ? new_cr_q : (sw_cr ? w_data_q[7:0] : cr_q);

   // ****************************************************************
   // Read-out shifter
   // ****************************************************************
   // [RQ3] status read-out
   // [RQ4] config read-out
   wire [7:0] reg_val = (opc_q == fscd_pkg::OPC_STATUS_READ) ? sr_q : cr_q;
   wire [7:0] cur     = (left_q == 3'd0) ? reg_val : out_q;
   wire [3:0] base    = (left_q == 3'd0) ? 4'd8 : {1'b0, left_q};
   wire [3:0] left_n  = base - step;

   always_comb begin
      out_d  = out_q;
      left_d = left_q;
      io_o_d = io_o_q;
      oe_n_d = oe_n_q;
      if (!active) begin
         left_d = 3'd0;
         oe_n_d = fscd_pkg::OE_N_OFF;
      end else if (in_read & sclk_fall) begin
         left_d = left_n[2:0];
         if (quad_q) begin
            io_o_d = cur[7:4];
            out_d  = {cur[3:0], 4'h0};
            oe_n_d = fscd_pkg::OE_N_QUAD;
         end else begin
            io_o_d = {2'b00, cur[7], 1'b0};
            out_d  = {cur[6:0], 1'b0};
            oe_n_d = fscd_pkg::OE_N_SINGLE;
         end
      end
   end

   // ****************************************************************
   // State flip-flops
   // ****************************************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= fscd_pkg::st_cmd;
         sh_q       <= 8'h00;
         bit_cnt_q  <= 3'd0;
         opc_q      <= 8'h00;
         exec_q     <= 1'b0;
         data_cnt_q <= 2'd0;
         new_sr_q   <= 8'h00;
         new_cr_q   <= 8'h00;
         out_q      <= 8'h00;
         left_q     <= 3'd0;
         io_o_q     <= 4'h0;
         oe_n_q     <= fscd_pkg::OE_N_OFF;
      end else begin
         state_q    <= state_d;
         sh_q       <= sh_d;
         bit_cnt_q  <= bit_cnt_d;
         opc_q      <= opc_d;
         exec_q     <= exec_d;
         data_cnt_q <= data_cnt_d;
         new_sr_q   <= new_sr_d;
         new_cr_q   <= new_cr_d;
         out_q      <= out_d;
         left_q     <= left_d;
         io_o_q     <= io_o_d;
         oe_n_q     <= oe_n_d;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wel_q  <= 1'b0;
         quad_q <= 1'b0;
         prot_q <= 1'b0;
         susp_q <= 1'b0;
         pd_q   <= 1'b0;
         busy_q <= 1'b0;
         sr_q   <= fscd_pkg::RST_STATUS;
         cr_q   <= fscd_pkg::RST_CONFIG;
      end else begin
         wel_q  <= wel_d;
         quad_q <= quad_d;
         prot_q <= prot_d;
         susp_q <= susp_d;
         pd_q   <= pd_d;
         busy_q <= busy_d;
         sr_q   <= sr_d;
         cr_q   <= cr_d;
      end
   end

   assign io_o                   = io_o_q;
   assign io_oe_n                = oe_n_q;
   assign write_enable_latch     = wel_q;
   assign four_line_command_mode = quad_q;
   assign individual_protect     = prot_q;
   assign op_suspended           = susp_q;
   assign deep_power_down        = pd_q;

endmodule

// >>> test/fscd_top_assertions.sv
`timescale 1ns/1ps
// ****************************************************************
// Port checks
// ****************************************************************
module fscd_top_assertions (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        reset_n,
   // Link
   input wire logic        cs_n,
   input wire logic [3:0]  io_oe_n,
   // Bus
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // State
   input wire logic        four_line_command_mode,
   input wire logic        individual_protect,
   input wire logic        deep_power_down
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
   a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   a_protect_sticky: assert property (!$fell(individual_protect))
      else $error("protect scheme fell");
   a_quad_enter: assert property ($rose(four_line_command_mode) |-> cs_n)
      else $error("quad entered inside a frame");
   a_quad_exit: assert property ($fell(four_line_command_mode) |-> cs_n)
      else $error("quad left inside a frame");
   a_pd_deselect: assert property ($changed(deep_power_down) |-> cs_n)
      else $error("power down moved inside a frame");
   a_oe_idle: assert property (cs_n [*5] |-> io_oe_n == fscd_pkg::OE_N_OFF)
      else $error("data lines driven while deselected");
   a_oe_mode: assert property ((io_oe_n == fscd_pkg::OE_N_QUAD) == four_line_command_mode
      || io_oe_n == fscd_pkg::OE_N_OFF) else $error("drive width not matching mode");
endmodule

// >>> test/fscd_host.sv
`timescale 1ns/1ps
// ****************************************************************
// Host controller on the link
// ****************************************************************
module fscd_host (
   // Clock
   input wire logic             clk,
   // Link
   input wire logic [3:0]       io_o,
   output fscd_pkg::fscd_link_t lnk
);
   logic quad = 1'b0;
   initial lnk = fscd_pkg::LINK_IDLE;
   task automatic half();
      repeat (16) @(posedge clk);
   endtask
   // MSB first, nibble per clock in quad
   task automatic put(input logic [7:0] b);
      for (int i = quad ? 1 : 7; i >= 0; i--) begin
         lnk.io <= quad ? b[i*4+:4] : {~lnk.io[3:1], b[i]};
         half();
         lnk.sclk <= 1'b1;
         half();
         lnk.sclk <= 1'b0;
      end
   endtask
   task automatic cmd(input logic [7:0] op, input int nw, input logic [15:0] wd,
                      input int nr, output logic [7:0] rd);
      lnk.cs_n <= 1'b0;
      half();
      put(op);
      // status byte, then optional config byte
      for (int k = 0; k < nw; k++) put(wd[15-8*k-:8]);
      // Released lines carry the inverse so a stale value cannot pass
      for (int k = 0; k < (quad ? 2 : 8) * nr; k++) begin
         lnk.io <= ~lnk.io;
         half();
         lnk.sclk <= 1'b1;
         rd = quad ? {rd[3:0], io_o} : {rd[6:0], io_o[1]};
         half();
         lnk.sclk <= 1'b0;
      end
      lnk.cs_n <= 1'b1;
      lnk.io <= ~lnk.io;
      // mode follows only the legal change
      quad <= op == 8'h35 ? 1'b1 : op == 8'hf5 ? 1'b0 : quad;
      repeat (40) @(posedge clk);
   endtask
endmodule

// >>> test/fscd_top_tb.sv
`timescale 1ns/1ps
module fscd_top_tb;
   logic                 mclk = 1'b0, reset_n = 1'b0, awv = 1'b0, wv = 1'b0;
   logic                 bry = 1'b0, arv = 1'b0, rry = 1'b0, awr, wr_r, bv, arr, rv;
   logic [7:0]           awa = '0, ara = '0, st = '0, cf = '0, rb;
   logic [31:0]          wd = '0, rdata, r = 32'hb600;
   logic [3:0]           io_o, oe_n;
   logic [1:0]           bresp, rresp;
   logic [4:0]           sv, es = '0;
   logic [33:0]          q[$];
   int                   errors = 0, tests_run = 0, cyc = 0;
   fscd_pkg::fscd_link_t lnk;
   initial forever #2.5 mclk = ~mclk;
   fscd_top dut_u (.mclk(mclk), .reset_n(reset_n), .cs_n(lnk.cs_n), .sclk(lnk.sclk),
      .io_i(lnk.io), .io_o(io_o), .io_oe_n(oe_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry),
      .write_enable_latch(sv[0]), .four_line_command_mode(sv[1]),
      .individual_protect(sv[2]), .op_suspended(sv[3]), .deep_power_down(sv[4]));
   fscd_host host_u (.clk(mclk), .io_o(io_o), .lnk(lnk));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic close_out();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge mclk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge mclk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr_r) wv <= 1'b0;
         if (bry && bv) begin
            bry <= 1'b0;
            chk("bresp", {32'h0, e}, {32'h0, bresp});
         end
      end while (awv || wv || bry);
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      q.push_back(e);
      @(posedge mclk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(posedge mclk);
         if (arv && arr) arv <= 1'b0;
         if (rry && rv) rry <= 1'b0;
      end while (arv || rry);
   endtask
   // Read results are matched in order of issue
   always @(posedge mclk) if (rv && rry && q.size() > 0) chk("rdata", q.pop_front(), {rresp, rdata});
   task automatic run(input logic [7:0] op, input int nw, input int nr);
      r = lfsr(r);
      host_u.cmd(op, nw, r[15:0], nr, rb);
      if (!es[4] || op == 8'hab) begin
         case (op)
            8'h06: es[0] = 1'b1;
            8'h04: es[0] = 1'b0;
            8'h68: es[2] = 1'b1;
            8'h35: es[1] = 1'b1;
            8'hf5: es[1] = 1'b0;
            8'hb0: es[3] = 1'b1;
            8'h30: es[3] = 1'b0;
            8'hb9: es[4] = 1'b1;
            8'hab: es[4] = 1'b0;
            8'h01: begin
               st = r[15:8];
               if (nw == 2) cf = r[7:0];
            end
            default: ;
         endcase
      end
      if (nr > 0) chk("link read", {26'h0, op == 8'h05 ? st : cf}, {26'h0, rb});
      chk("state pins", {29'h0, es}, {29'h0, sv});
      rd(fscd_pkg::OFF_STATE, {18'h0, op, 3'b000, es});
      rd(fscd_pkg::OFF_STATUS, {26'h0, st});
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         errors++;
         close_out();
      end
   end
   initial begin
      repeat (12) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (6) @(posedge mclk);
      rd(fscd_pkg::OFF_CONFIG, {26'h0, fscd_pkg::RST_CONFIG});
      rd(8'h10, {fscd_pkg::RESP_DECERR, 32'h0});
      wr(8'h20, 32'h1, fscd_pkg::RESP_DECERR);
      wr(fscd_pkg::OFF_CONTROL, 32'h1, fscd_pkg::RESP_OKAY);
      run(8'h06, 0, 0);
      run(8'h04, 0, 0);
      run(8'h01, 2, 0);
      run(8'h05, 0, 1);
      run(8'h15, 0, 1);
      run(8'h01, 1, 0);
      run(8'h68, 0, 0);
      run(8'hf5, 0, 0);
      run(8'h35, 0, 0);
      run(8'h35, 0, 0);
      run(8'h06, 0, 0);
      run(8'h05, 0, 1);
      run(8'hb0, 0, 0);
      run(8'h30, 0, 0);
      run(8'hf5, 0, 0);
      run(8'h04, 0, 0);
      run(8'hb9, 0, 0);
      run(8'h06, 0, 0);
      run(8'hab, 0, 0);
      r = lfsr(r);
      st = r[7:0];
      wr(fscd_pkg::OFF_STATUS, {24'h0, st}, fscd_pkg::RESP_OKAY);
      run(8'h05, 0, 1);
      close_out();
   end
endmodule
bind fscd_top fscd_top_assertions chk_u (.mclk, .reset_n, .cs_n, .io_oe_n, .s_axi_awready,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
   .four_line_command_mode, .individual_protect, .deep_power_down);
